// File: common/bpt_defines.vh
// bcd preset timer bank: register offsets, field positions, reset values
// and timing counts. assumes a 200 MHz system clock.
`ifndef BPT_DEFINES_VH
`define BPT_DEFINES_VH

`define BPT_CLK_HZ          200000000
`define BPT_TENTH_NS        100000000
`define BPT_HUNDREDTH_NS    10000000
`define BPT_CLK_NS          5
`define BPT_TENTH_CYCLES    (`BPT_TENTH_NS / `BPT_CLK_NS)
`define BPT_HUNDREDTH_CYCLES (`BPT_HUNDREDTH_NS / `BPT_CLK_NS)

// register word offsets (byte offsets, one word each)
`define BPT_REG_CTRL        8'h00
`define BPT_REG_STATUS      8'h04
`define BPT_REG_IRQ_STAT    8'h08
`define BPT_REG_IRQ_MASK    8'h0c
`define BPT_REG_PRESET_BASE 8'h40
`define BPT_REG_VALUE_BASE  8'h80

// control register fields
`define BPT_CTRL_RUN_LSB    0
`define BPT_CTRL_RST_LSB    8

`define BPT_CTRL_RESET      16'h0000
`define BPT_MASK_RESET      8'h00

// kinds of timer
`define BPT_KIND_TENTH      2'd0
`define BPT_KIND_HUNDREDTH  2'd1
`define BPT_KIND_ACC_TENTH  2'd2
`define BPT_KIND_ACC_HUND   2'd3

`endif

// File: rtl/bpt_bcd_timer.v
// bpt_bcd_timer: one bcd preset timer, single-word or accumulating.
// assumes a shared tick pulse on the same clock and a preset held stable
// by the caller.
`timescale 1ns/1ps
`include "bpt_defines.vh"

module bpt_bcd_timer
#(
  parameter DIGITS = 4,
  parameter ACCUM  = 0
)
(
  // clock and reset
  input  wire                  clock_in,
  input  wire                  sys_rst_in,
  // control
  input  wire                  tick_in,
  input  wire                  enable_in,
  input  wire                  clear_in,
  input  wire [4*DIGITS-1:0]   preset_in,
  // state
  output reg  [4*DIGITS-1:0]   value_out,
  output wire                  done_out,
  output wire                  done_rise_out
);

  reg  [4*DIGITS-1:0] inc_d;
  reg                 all_nine;
  reg                 carry;
  reg                 done_q;
  integer             i;

  // bcd increment with decimal carry; stays at all nines
  always @*
  begin
    inc_d    = value_out;
    all_nine = 1'b1;
    carry    = 1'b1;
    for (i = 0; i < DIGITS; i = i + 1)
    begin
      if (value_out[4*i +: 4] != 4'h9)
        all_nine = 1'b0;
      if (carry)
      begin
        if (value_out[4*i +: 4] == 4'h9)
          inc_d[4*i +: 4] = 4'h0;
        else
        begin
          inc_d[4*i +: 4] = value_out[4*i +: 4] + 4'h1;
          carry = 1'b0;
        end
      end
    end
  end

  always @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      value_out <= {4*DIGITS{1'b0}};
    else if (ACCUM != 0 && clear_in)
      value_out <= {4*DIGITS{1'b0}};
    else if (ACCUM == 0 && !enable_in)
      value_out <= {4*DIGITS{1'b0}};
    else if (enable_in && tick_in && !all_nine)
      value_out <= inc_d;
  end

  // packed bcd compares like binary, so plain magnitude works
  assign done_out = (value_out >= preset_in);

  // value and preset both reset to zero, so done is high out of reset;
  // starting the edge detector high keeps that from posting an event
  always @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      done_q <= 1'b1;
    else
      done_q <= done_out;
  end

  assign done_rise_out = done_out & ~done_q;

endmodule // bpt_bcd_timer

// File: rtl/bpt_timer_bank.v
// bpt_timer_bank: four bcd preset timers (tenth, hundredth, accumulating
// tenth, accumulating hundredth) with a register port and interrupt.
// assumes run and reset inputs come from pins in another clock domain.
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "bpt_defines.vh"

// How it works
// - single timer runs while input on, else clears
// - standard single timer ticks 0.1 s, max 999.9
// - fast single timer ticks 0.01 s, max 99.99
// - done while current value at least preset
// - single timers hold one 16-bit bcd word
// - accumulating timer holds value while enable off
// - accumulating reset input forces value to zero
// - accumulating tenth timer, max 9999999.9 seconds
// - accumulating hundredth timer, eight digits, max 999999.99
// - accumulating values take two consecutive value words
// - timers 0 to 2 current value starts at word n, timer 3 at word 4
module bpt_timer_bank
#(
  parameter TENTH_CYCLES     = `BPT_TENTH_CYCLES,
  parameter HUNDREDTH_CYCLES = `BPT_HUNDREDTH_CYCLES
)
(
  // clock and reset
  input  wire        clock_in,
  input  wire        sys_rst_in,
  // timer inputs from ladder pins
  input  wire [3:0]  timer_run_in,
  input  wire [3:2]  timer_clear_in,
  // register port
  input  wire [7:0]  reg_addr_in,
  input  wire [31:0] reg_wdata_in,
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  output reg  [31:0] reg_rdata_out,
  // status
  output wire [3:0]  timer_done_out,
  output wire        irq_out
);

  // pin synchronisers
  reg  [5:0]  sync1_q;
  reg  [5:0]  sync2_q;
  always @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
    end
    else
    begin
      sync1_q <= {timer_clear_in, timer_run_in};
      sync2_q <= sync1_q;
    end
  end

  // registers
  reg  [15:0] ctrl_q;
  reg  [3:0]  irq_stat_q;
  reg  [3:0]  irq_mask_q;
  reg  [15:0] preset0_q;
  reg  [15:0] preset1_q;
  reg  [31:0] preset2_q;
  reg  [31:0] preset3_q;

  // a timer runs when its pin or its software bit is on
  wire [3:0] run_w   = sync2_q[3:0] | ctrl_q[`BPT_CTRL_RUN_LSB +: 4];
  wire [1:0] clear_w = sync2_q[5:4] | ctrl_q[`BPT_CTRL_RST_LSB +: 2];

  // prescalers; one per tick rate, shared by both timers of that rate
  localparam TW = 25;
  reg  [TW-1:0] pre_tenth_q;
  reg  [TW-1:0] pre_hund_q;
  wire          tick_tenth = (pre_tenth_q == TENTH_CYCLES - 1);
  wire          tick_hund  = (pre_hund_q == HUNDREDTH_CYCLES - 1);

  always @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      pre_tenth_q <= {TW{1'b0}};
      pre_hund_q  <= {TW{1'b0}};
    end
    else
    begin
      pre_tenth_q <= tick_tenth ? {TW{1'b0}} : pre_tenth_q + 1'b1;
      pre_hund_q  <= tick_hund  ? {TW{1'b0}} : pre_hund_q + 1'b1;
    end
  end

  wire [15:0] value0;
  wire [15:0] value1;
  wire [31:0] value2;
  wire [31:0] value3;
  wire [3:0]  done_rise;

  // tenth_second_timer: 4 bcd digits, 0.1 s ticks
  bpt_bcd_timer #(.DIGITS(4), .ACCUM(0)) u_tenth_second_timer (
    .clock_in      (clock_in),
    .sys_rst_in    (sys_rst_in),
    .tick_in       (tick_tenth),
    .enable_in     (run_w[0]),
    .clear_in      (1'b0),
    .preset_in     (preset0_q),
    .value_out     (value0),
    .done_out      (timer_done_out[0]),
    .done_rise_out (done_rise[0])
  );

  // hundredth_second_timer: 4 bcd digits, 0.01 s ticks
  bpt_bcd_timer #(.DIGITS(4), .ACCUM(0)) u_hundredth_second_timer (
    .clock_in      (clock_in),
    .sys_rst_in    (sys_rst_in),
    .tick_in       (tick_hund),
    .enable_in     (run_w[1]),
    .clear_in      (1'b0),
    .preset_in     (preset1_q),
    .value_out     (value1),
    .done_out      (timer_done_out[1]),
    .done_rise_out (done_rise[1])
  );

  // accum_tenth_timer: 8 bcd digits, 0.1 s ticks
  bpt_bcd_timer #(.DIGITS(8), .ACCUM(1)) u_accum_tenth_timer (
    .clock_in      (clock_in),
    .sys_rst_in    (sys_rst_in),
    .tick_in       (tick_tenth),
    .enable_in     (run_w[2]),
    .clear_in      (clear_w[0]),
    .preset_in     (preset2_q),
    .value_out     (value2),
    .done_out      (timer_done_out[2]),
    .done_rise_out (done_rise[2])
  );

  // accum_hundredth_timer: 8 bcd digits, 0.01 s ticks, saturates 99999999
  bpt_bcd_timer #(.DIGITS(8), .ACCUM(1)) u_accum_hundredth_timer (
    .clock_in      (clock_in),
    .sys_rst_in    (sys_rst_in),
    .tick_in       (tick_hund),
    .enable_in     (run_w[3]),
    .clear_in      (clear_w[1]),
    .preset_in     (preset3_q),
    .value_out     (value3),
    .done_out      (timer_done_out[3]),
    .done_rise_out (done_rise[3])
  );

  // value words: timers 0 to 2 start at word n; accumulators span two words, so
  // timers sit at words 0, 1, 2..3 and 4..5
  function [3:0] value_word;
    input [7:0] addr;
    begin
      value_word = addr[5:2];
    end
  endfunction

  wire wr_ctrl   = reg_wr_in && reg_addr_in == `BPT_REG_CTRL;
  wire wr_istat  = reg_wr_in && reg_addr_in == `BPT_REG_IRQ_STAT;
  wire wr_imask  = reg_wr_in && reg_addr_in == `BPT_REG_IRQ_MASK;
  wire wr_preset = reg_wr_in && reg_addr_in[7:6] == 2'b01;

  always @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      ctrl_q     <= `BPT_CTRL_RESET;
      irq_mask_q <= 4'h0;
      preset0_q  <= 16'h0000;
      preset1_q  <= 16'h0000;
      preset2_q  <= 32'h00000000;
      preset3_q  <= 32'h00000000;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= reg_wdata_in[15:0];
      if (wr_imask)
        irq_mask_q <= reg_wdata_in[3:0];
      // presets in the program's own bcd; range is its responsibility
      if (wr_preset)
      begin
        case (value_word(reg_addr_in))
          4'h0: preset0_q <= reg_wdata_in[15:0];
          4'h1: preset1_q <= reg_wdata_in[15:0];
          4'h2: preset2_q[15:0]  <= reg_wdata_in[15:0];
          4'h3: preset2_q[31:16] <= reg_wdata_in[15:0];
          4'h4: preset3_q[15:0]  <= reg_wdata_in[15:0];
          4'h5: preset3_q[31:16] <= reg_wdata_in[15:0];
          default: ;
        endcase
      end
    end
  end

  // sticky done events; a new event beats a write-one clear
  always @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      irq_stat_q <= 4'h0;
    else
      irq_stat_q <= (irq_stat_q & ~(wr_istat ? reg_wdata_in[3:0] : 4'h0))
                    | done_rise;
  end

  assign irq_out = |(irq_stat_q & irq_mask_q);

  reg [15:0] vword;
  always @*
  begin
    case (value_word(reg_addr_in))
      4'h0:    vword = value0;
      4'h1:    vword = value1;
      4'h2:    vword = value2[15:0];
      4'h3:    vword = value2[31:16];
      4'h4:    vword = value3[15:0];
      4'h5:    vword = value3[31:16];
      default: vword = 16'h0000;
    endcase
  end

  always @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      reg_rdata_out <= 32'h00000000;
    else if (reg_rd_in)
    begin
      if (reg_addr_in == `BPT_REG_CTRL)
        reg_rdata_out <= {16'h0000, ctrl_q};
      else if (reg_addr_in == `BPT_REG_STATUS)
        reg_rdata_out <= {28'h0000000, timer_done_out};
      else if (reg_addr_in == `BPT_REG_IRQ_STAT)
        reg_rdata_out <= {28'h0000000, irq_stat_q};
      else if (reg_addr_in == `BPT_REG_IRQ_MASK)
        reg_rdata_out <= {28'h0000000, irq_mask_q};
      else if (reg_addr_in[7:6] == 2'b10)
        reg_rdata_out <= {16'h0000, vword};
      else
        reg_rdata_out <= 32'h00000000;
    end
    else
      reg_rdata_out <= 32'h00000000;
  end

endmodule // bpt_timer_bank

// File: bench/bpt_ladder_model.sv
// bpt_ladder_model: stands in for the ladder program that drives timer
// enables and resets; assumes requests come from the bench each cycle.
`timescale 1ns/1ps
module bpt_ladder_model
(
  // clock
  input  wire       clock_in,
  // requests from the bench
  input  wire [3:0] run_req_in,
  input  wire [3:2] clr_req_in,
  // pin levels to the bank
  output reg  [3:0] run_out,
  output reg  [3:2] clr_out
);
  // pins change only after an edge, as a scanned program would
  always @(posedge clock_in)
  begin
    run_out <= run_req_in;
    clr_out <= clr_req_in;
  end
endmodule // bpt_ladder_model

// File: bench/bpt_timer_bank_monitor.sv
// bpt_timer_bank_monitor: port checks of the timer bank.
// assumes the bench never sets the software run bit of timer 0.
`timescale 1ns/1ps
module bpt_timer_bank_monitor
(
  // clock and reset
  input wire        clock_in,
  input wire        sys_rst_in,
  // watched ports
  input wire [3:0]  timer_run_in,
  input wire [3:2]  timer_clear_in,
  input wire [7:0]  reg_addr_in,
  input wire        reg_rd_in,
  input wire [31:0] reg_rdata_out,
  input wire [3:0]  timer_done_out,
  input wire        irq_out
);
  wire rd_val;
  wire bcd_ok;
  assign rd_val = reg_rd_in && reg_addr_in[7:6] == 2'b10;
  assign bcd_ok = reg_rdata_out[3:0] < 4'ha && reg_rdata_out[7:4] < 4'ha
    && reg_rdata_out[11:8] < 4'ha && reg_rdata_out[15:12] < 4'ha;
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  a_rd_quiet: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 0)
    else $error("read data outside its slot");
  a_unmapped_rd: assert property
    (reg_rd_in && reg_addr_in == 8'h10 |=> reg_rdata_out == 0)
    else $error("unmapped read not zero");
  a_value_upper: assert property
    (rd_val |=> reg_rdata_out[31:16] == 16'h0)
    else $error("value word wider than 16 bits");
  a_value_bcd: assert property (rd_val |=> bcd_ok)
    else $error("value word not bcd");
  a_single_clear: assert property
    ((!timer_run_in[0])[*8] ##0 (reg_rd_in && reg_addr_in == 8'h80)
     |=> reg_rdata_out == 0)
    else $error("idle single timer not cleared");
  a_acc_clear: assert property
    (timer_clear_in[2][*8] ##0 (reg_rd_in && reg_addr_in == 8'h88)
     |=> reg_rdata_out == 0)
    else $error("accum value kept under reset");
  a_done_reset: assert property
    ($fell(sys_rst_in) |-> timer_done_out == 4'hf)
    else $error("done not set at zero preset");
  a_irq_reset: assert property ($fell(sys_rst_in) |-> !irq_out)
    else $error("interrupt high after reset");
  cover property (timer_done_out[0] && timer_run_in[0]);
  cover property (irq_out);
  cover property (reg_rd_in && reg_addr_in == 8'h94);
endmodule // bpt_timer_bank_monitor

// File: bench/bpt_timer_bank_test.sv
// bpt_timer_bank_test: register table, then timer scenarios.
// assumes ticks shortened to 20 and 4 clocks.
`timescale 1ns/1ps
module bpt_timer_bank_test;
  localparam TEN = 20;
  localparam HUN = 4;
  reg         clock_in;
  reg         sys_rst_in;
  reg  [3:0]  run_req;
  reg  [3:2]  clr_req;
  wire [3:0]  timer_run;
  wire [3:2]  timer_clear;
  reg  [7:0]  reg_addr;
  reg  [31:0] reg_wdata;
  reg         reg_wr;
  reg         reg_rd;
  wire [31:0] reg_rdata;
  wire [3:0]  timer_done;
  wire        irq;
  integer     failures;
  integer     cmp_count;
  integer     i;
  reg  [40:0] rows [0:6];
  bpt_ladder_model lad_u (.clock_in(clock_in), .run_req_in(run_req),
    .clr_req_in(clr_req), .run_out(timer_run), .clr_out(timer_clear));
  bpt_timer_bank #(.TENTH_CYCLES(TEN), .HUNDREDTH_CYCLES(HUN)) dut_u (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .timer_run_in(timer_run), .timer_clear_in(timer_clear),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
    .timer_done_out(timer_done), .irq_out(irq));
  initial
  begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  task complete_run;
  begin
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task wr_reg(input [7:0] a, input [31:0] d);
  begin
    @(posedge clock_in);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock_in);
    reg_wr <= 1'b0;
  end
  endtask
  task rd_chk(input [7:0] a, input [31:0] e);
  begin
    @(posedge clock_in);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock_in);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  end
  endtask
  task pins(input [3:0] r, input [3:2] c);
  begin
    @(posedge clock_in);
    run_req <= r;
    clr_req <= c;
  end
  endtask
  // a wait that runs out ends the run at once
  task wait_done(input integer b, input integer lim);
    integer n;
  begin
    n = 0;
    while (timer_done[b] !== 1'b1 && n < lim)
    begin
      @(negedge clock_in);
      n = n + 1;
    end
    chk({31'h0, n < lim}, 32'h1);
    if (n >= lim)
      complete_run;
  end
  endtask
  initial
  begin
    failures = 0;
    cmp_count = 0;
    sys_rst_in = 1'b1;
    run_req = 4'h0;
    clr_req = 2'b00;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    // {write, address, write data, expected read}
    rows[0] = {1'b0, 8'h04, 16'h0000, 16'h000f};
    rows[1] = {1'b0, 8'h10, 16'h0000, 16'h0000};
    rows[2] = {1'b1, 8'h10, 16'h1234, 16'h0000};
    rows[3] = {1'b1, 8'h0c, 16'h0001, 16'h0001};
    // preset words are write-only; their reads return zero
    rows[4] = {1'b1, 8'h40, 16'h0003, 16'h0000};
    rows[5] = {1'b0, 8'h04, 16'h0000, 16'h000e};
    rows[6] = {1'b0, 8'h80, 16'h0000, 16'h0000};
    repeat (4) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    for (i = 0; i < 7; i = i + 1)
    begin
      if (rows[i][40])
        wr_reg(rows[i][39:32], {16'h0, rows[i][31:16]});
      rd_chk(rows[i][39:32], {16'h0, rows[i][15:0]});
    end
    pins(4'h1, 2'b00);
    wait_done(0, 4 * TEN + 10);
    rd_chk(8'h80, 32'h3);
    chk({31'h0, irq}, 32'h1);
    wr_reg(8'h08, 32'h1);
    // the clear lands on the edge that ends the write; look after it
    #1 chk({31'h0, irq}, 32'h0);
    pins(4'h0, 2'b00);
    repeat (5) @(posedge clock_in);
    rd_chk(8'h80, 32'h0);
    chk({31'h0, timer_done[0]}, 32'h0);
    wr_reg(8'h48, 32'h2);
    pins(4'h4, 2'b01);
    repeat (3 * TEN) @(posedge clock_in);
    rd_chk(8'h88, 32'h0);
    pins(4'h4, 2'b00);
    wait_done(2, 3 * TEN + 10);
    pins(4'h0, 2'b00);
    repeat (3 * TEN) @(posedge clock_in);
    rd_chk(8'h88, 32'h2);
    rd_chk(8'h8c, 32'h0);
    wr_reg(8'h48, 32'h4);
    pins(4'h4, 2'b00);
    // a restart from zero would need four more ticks
    wait_done(2, 2 * TEN + 6);
    wr_reg(8'h44, 32'h9999);
    wr_reg(8'h54, 32'h1);
    pins(4'ha, 2'b00);
    wait_done(3, 10010 * HUN);
    rd_chk(8'h94, 32'h1);
    repeat (10 * HUN) @(posedge clock_in);
    rd_chk(8'h84, 32'h9999);
    chk({31'h0, timer_done[1]}, 32'h1);
    // software clear of the stopped accumulator, then let it go again
    wr_reg(8'h00, 32'h100);
    rd_chk(8'h00, 32'h100);
    rd_chk(8'h88, 32'h0);
    wr_reg(8'h00, 32'h0);
    pins(4'h0, 2'b00);
    @(posedge clock_in);
    sys_rst_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    rd_chk(8'h04, 32'hf);
    rd_chk(8'h94, 32'h0);
    complete_run;
  end
endmodule // bpt_timer_bank_test
bind bpt_timer_bank bpt_timer_bank_monitor mon_u (
  .clock_in(clock_in), .sys_rst_in(sys_rst_in),
  .timer_run_in(timer_run_in), .timer_clear_in(timer_clear_in),
  .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .timer_done_out(timer_done_out),
  .irq_out(irq_out));
